// file: src/mac_status_unit.sv
// Functional notes
// - Negative flag copies result msb, only on accumulate and load operations.
// - Zero flag follows result equal zero, only on accumulate and load.
// - Overflow flag is sticky until accumulator load or status write.
// - Plain multiplies never touch the overflow flag.
// - Carry bit of the status register always reads zero.
// - Integer mode signedness from sign-select; round/truncate ignored there.
// - Fraction-select forces signed fractions; sign-select then picks store rounding.
// - Fractional, sign-select clear: accumulator store returns full 32 bits.
// - Fractional, sign-select set: store rounds 32 bits to 16, nearest even.
// - Rounded store puts result in low half, upper half zero.
// - Store rounding leaves the accumulator itself unchanged.
// - Fractional long accumulate truncates product, or rounds when round/truncate set.
// - Discarded half below midpoint keeps upper half as is.
// - Discarded half above midpoint increments upper half.
// - Exact midpoint rounds toward even upper half.
// - Plain multiplies always treat operands as integers.
// - Scale factor ignored in fractional mode.
// - Round/truncate bit 4, fraction-select bit 5, sign-select bit 6.
`timescale 1ns/10ps
`default_nettype none

module mac_status_unit
(
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  input  wire logic                 op_valid,
  input  wire mac_status_pkg::op_t  op_code,
  input  wire logic                 op_long,
  input  wire mac_status_pkg::scale_t scale_sel,
  input  wire logic [31:0]          operand_y,
  input  wire logic [31:0]          operand_x,
  input  wire logic [31:0]          load_data,
  output logic [31:0]               result_data,
  output logic                      result_valid,
  output logic [31:0]               accum_value,
  output logic [31:0]               status_value
);

  logic [31:0] acc_reg;
  logic [31:0] acc_next;
  logic        neg_reg;
  logic        zero_reg;
  logic        ovf_reg;
  logic        rt_reg;
  logic        fi_reg;
  logic        su_reg;
  logic        omc_reg;
  logic [31:0] result_reg;
  logic [31:0] result_next;
  logic        result_valid_reg;

  logic signed [63:0] prod_s64;
  logic [63:0]        prod_u64;
  logic signed [31:0] prod_sw;
  logic [31:0]        prod_uw;
  logic [31:0]        term;
  logic               term_ovf;
  logic [32:0]        combined;
  logic               is_accum;
  logic               is_sub;
  logic               signed_mode;
  logic [31:0]        store_value;

  round_if #(.W(mac_status_pkg::DATA_W)) store_rif ();
  round_if #(.W(mac_status_pkg::LONG_W)) prod_rif ();

  convergent_rounder #(.W(mac_status_pkg::DATA_W)) u_store_round
  (
    .rif (store_rif.rounder)
  );

  convergent_rounder #(.W(mac_status_pkg::LONG_W)) u_prod_round
  (
    .rif (prod_rif.rounder)
  );

  // Add or subtract with overflow in the chosen number system
  function automatic logic [32:0] combine_acc
  (
    input logic [31:0] acc,
    input logic [31:0] val,
    input logic        sub,
    input logic        sgn
  );
    logic [32:0] wide;
    logic        ovf;
    wide = sub ? ({1'b0, acc} - {1'b0, val}) : ({1'b0, acc} + {1'b0, val});
    if (sgn)
      ovf = sub ? ((acc[31] != val[31]) && (wide[31] != acc[31]))
                : ((acc[31] == val[31]) && (wide[31] != acc[31]));
    else
      ovf = wide[32];
    return {ovf, wide[31:0]};
  endfunction

  assign is_accum = op_valid && ((op_code == mac_status_pkg::OP_MAC) ||
                                 (op_code == mac_status_pkg::OP_MSAC));
  assign is_sub   = (op_code == mac_status_pkg::OP_MSAC);
  // Fractions are always signed; integers follow sign-select
  assign signed_mode = fi_reg || !su_reg;

  assign prod_s64 = $signed(operand_y) * $signed(operand_x);
  assign prod_u64 = {32'h0000_0000, operand_y} * {32'h0000_0000, operand_x};
  assign prod_sw  = $signed(operand_y[15:0]) * $signed(operand_x[15:0]);
  assign prod_uw  = {16'h0000, operand_y[15:0]} * {16'h0000, operand_x[15:0]};

  // Fractional long product aligned before rounding
  assign prod_rif.full = {prod_s64[62:0], 1'b0};

  // Product term fed to the accumulator
  always_comb
  begin
    term     = prod_uw;
    term_ovf = 1'b0;
    if (fi_reg)
    begin
      // No scale shift in fractional mode
      if (op_long)
      begin
        term = rt_reg ? prod_rif.rounded : prod_rif.full[63:32];
        term_ovf = prod_s64[63] ^ prod_s64[62];
      end
      else
      begin
        term = {prod_sw[30:0], 1'b0};
        term_ovf = prod_sw[31] ^ prod_sw[30];
      end
    end
    else
    begin
      if (op_long)
      begin
        term = signed_mode ? prod_s64[31:0] : prod_u64[31:0];
        term_ovf = signed_mode ? !((&prod_s64[63:31]) || !(|prod_s64[63:31]))
                               : (|prod_u64[63:32]);
      end
      else
      begin
        term = signed_mode ? prod_sw : prod_uw;
      end
      case (scale_sel)
        mac_status_pkg::SCALE_LEFT:
        begin
          term_ovf = term_ovf || (signed_mode ? (term[31] ^ term[30])
                                              : term[31]);
          term = {term[30:0], 1'b0};
        end
        mac_status_pkg::SCALE_RIGHT:
        begin
          term = {signed_mode & term[31], term[31:1]};
        end
        default: ;
      endcase
    end
  end

  assign combined = combine_acc(acc_reg, term, is_sub, signed_mode);

  // Accumulator
  always_comb
  begin
    acc_next = acc_reg;
    if (op_valid && (op_code == mac_status_pkg::OP_LOAD_ACC))
      acc_next = load_data;
    else if (is_accum)
      acc_next = combined[31:0];
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      acc_reg <= mac_status_pkg::ACC_RESET;
    else
      acc_reg <= acc_next;
  end

  // Negative and zero flags
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      neg_reg  <= mac_status_pkg::SR_RESET[mac_status_pkg::SR_NEG_BIT];
      zero_reg <= mac_status_pkg::SR_RESET[mac_status_pkg::SR_ZERO_BIT];
    end
    else if (op_valid && (op_code == mac_status_pkg::OP_LOAD_SR))
    begin
      neg_reg  <= load_data[mac_status_pkg::SR_NEG_BIT];
      zero_reg <= load_data[mac_status_pkg::SR_ZERO_BIT];
    end
    else if (is_accum || (op_valid &&
             (op_code == mac_status_pkg::OP_LOAD_ACC)))
    begin
      neg_reg  <= acc_next[31];
      zero_reg <= (acc_next == 32'h0000_0000);
    end
  end

  // Sticky overflow; multiplies do not reach it
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      ovf_reg <= mac_status_pkg::SR_RESET[mac_status_pkg::SR_OVF_BIT];
    else if (op_valid && (op_code == mac_status_pkg::OP_LOAD_SR))
      ovf_reg <= load_data[mac_status_pkg::SR_OVF_BIT];
    else if (op_valid && (op_code == mac_status_pkg::OP_LOAD_ACC))
      ovf_reg <= 1'b0;
    else if (is_accum && (term_ovf || combined[32]))
      ovf_reg <= 1'b1;
  end

  // Mode bits, written only by a status load
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rt_reg  <= mac_status_pkg::SR_RESET[mac_status_pkg::SR_RT_BIT];
      fi_reg  <= mac_status_pkg::SR_RESET[mac_status_pkg::SR_FI_BIT];
      su_reg  <= mac_status_pkg::SR_RESET[mac_status_pkg::SR_SU_BIT];
      omc_reg <= mac_status_pkg::SR_RESET[mac_status_pkg::SR_OMC_BIT];
    end
    else if (op_valid && (op_code == mac_status_pkg::OP_LOAD_SR))
    begin
      rt_reg  <= load_data[mac_status_pkg::SR_RT_BIT];
      fi_reg  <= load_data[mac_status_pkg::SR_FI_BIT];
      su_reg  <= load_data[mac_status_pkg::SR_SU_BIT];
      omc_reg <= load_data[mac_status_pkg::SR_OMC_BIT];
    end
  end

  always_comb
  begin
    status_value = 32'h0000_0000;
    status_value[mac_status_pkg::SR_OMC_BIT]   = omc_reg;
    status_value[mac_status_pkg::SR_SU_BIT]    = su_reg;
    status_value[mac_status_pkg::SR_FI_BIT]    = fi_reg;
    status_value[mac_status_pkg::SR_RT_BIT]    = rt_reg;
    status_value[mac_status_pkg::SR_NEG_BIT]   = neg_reg;
    status_value[mac_status_pkg::SR_ZERO_BIT]  = zero_reg;
    status_value[mac_status_pkg::SR_OVF_BIT]   = ovf_reg;
    status_value[mac_status_pkg::SR_CARRY_BIT] = 1'b0;
  end

  // Accumulator store path
  assign store_rif.full = acc_reg;
  assign store_value = (fi_reg && su_reg)
                     ? {mac_status_pkg::UPPER_ZERO, store_rif.rounded}
                     : acc_reg;

  always_comb
  begin
    result_next = result_reg;
    case (op_code)
      mac_status_pkg::OP_MULS:
        result_next = op_long ? prod_s64[31:0] : prod_sw;
      mac_status_pkg::OP_MULU:
        result_next = op_long ? prod_u64[31:0] : prod_uw;
      mac_status_pkg::OP_STORE_ACC:
        result_next = store_value;
      mac_status_pkg::OP_STORE_SR:
        result_next = status_value;
      default:
        result_next = result_reg;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      result_reg <= 32'h0000_0000;
    else if (op_valid)
      result_reg <= result_next;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      result_valid_reg <= 1'b0;
    else
      result_valid_reg <= op_valid &&
                          ((op_code == mac_status_pkg::OP_MULS) ||
                           (op_code == mac_status_pkg::OP_MULU) ||
                           (op_code == mac_status_pkg::OP_STORE_ACC) ||
                           (op_code == mac_status_pkg::OP_STORE_SR));
  end

  assign result_data  = result_reg;
  assign result_valid = result_valid_reg;
  assign accum_value  = acc_reg;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  logic [32:0] ref_round;
  assign ref_round = {1'b0, acc_reg} + 33'h0_0000_7fff + {32'h0, acc_reg[16]};

  sequence s_flag_op;
    op_valid && ((op_code == mac_status_pkg::OP_MAC) ||
                 (op_code == mac_status_pkg::OP_MSAC) ||
                 (op_code == mac_status_pkg::OP_LOAD_ACC));
  endsequence
  sequence s_plain_mul;
    op_valid && ((op_code == mac_status_pkg::OP_MULS) ||
                 (op_code == mac_status_pkg::OP_MULU));
  endsequence
  sequence s_round_store;
    op_valid && (op_code == mac_status_pkg::OP_STORE_ACC) && fi_reg && su_reg;
  endsequence
  sequence s_plain_store;
    op_valid && (op_code == mac_status_pkg::OP_STORE_ACC) &&
    !(fi_reg && su_reg);
  endsequence

  a_neg_follows_msb: assert property
    (s_flag_op |=> status_value[3] == accum_value[31])
    else $error("negative flag differs from accumulator msb");

  a_zero_follows_acc: assert property
    (s_flag_op |=> status_value[2] == (accum_value == 32'h0000_0000))
    else $error("zero flag differs from accumulator value");

  a_ovf_sticky_hold: assert property
    (ovf_reg && !(op_valid && ((op_code == mac_status_pkg::OP_LOAD_ACC) ||
                 (op_code == mac_status_pkg::OP_LOAD_SR))) |=> ovf_reg)
    else $error("overflow flag dropped without a load");

  a_mul_keeps_flags: assert property
    (s_plain_mul |=> $stable(status_value[3:1]))
    else $error("plain multiply altered status flags");

  a_carry_reads_zero: assert property
    (status_value[0] == 1'b0)
    else $error("carry bit not zero");

  a_store_plain_value: assert property
    (s_plain_store |=> result_valid && result_data == $past(acc_reg))
    else $error("unrounded store returned wrong value");

  a_store_round_value: assert property
    (s_round_store |=> result_data[15:0] == $past(ref_round[31:16]))
    else $error("rounded store value wrong");

  a_store_upper_zero: assert property
    (s_round_store |=> result_valid ##0 result_data[31:16] == 16'h0000)
    else $error("rounded store upper half not zero");

  a_store_keeps_acc: assert property
    (s_round_store |=> $stable(acc_reg))
    else $error("store altered accumulator");

  a_round_below_half: assert property
    (acc_reg[15:0] < 16'h8000 |-> store_rif.rounded == acc_reg[31:16])
    else $error("below midpoint was not truncated");

  a_round_above_half: assert property
    (acc_reg[15:0] > 16'h8000 |-> store_rif.rounded == acc_reg[31:16] + 16'h0001)
    else $error("above midpoint was not incremented");

  a_round_tie_even: assert property
    (acc_reg[15:0] == 16'h8000 |-> store_rif.rounded[0] == 1'b0)
    else $error("midpoint did not round to even");

endmodule

`default_nettype wire

// file: src/mac_status_pkg.sv
package mac_status_pkg;

  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int LONG_W = 64;

  // Status register field positions
  localparam int SR_CARRY_BIT = 0;
  localparam int SR_OVF_BIT   = 1;
  localparam int SR_ZERO_BIT  = 2;
  localparam int SR_NEG_BIT   = 3;
  localparam int SR_RT_BIT    = 4;
  localparam int SR_FI_BIT    = 5;
  localparam int SR_SU_BIT    = 6;
  localparam int SR_OMC_BIT   = 7;

  // Values after reset
  localparam logic [31:0] SR_RESET  = 32'h0000_0000;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;

  localparam logic [15:0] UPPER_ZERO = 16'h0000;
  localparam logic [31:0] MOST_NEG   = 32'h8000_0000;

  typedef enum logic [3:0] {
    OP_NONE,
    OP_MAC,
    OP_MSAC,
    OP_MULS,
    OP_MULU,
    OP_LOAD_ACC,
    OP_STORE_ACC,
    OP_LOAD_SR,
    OP_STORE_SR
  } op_t;

  typedef enum logic [1:0] {
    SCALE_NONE,
    SCALE_LEFT,
    SCALE_RIGHT,
    SCALE_SPARE
  } scale_t;

endpackage

// file: src/round_if.sv
`timescale 1ns/10ps
`default_nettype none

interface round_if #(parameter int W = 32);
  logic [W-1:0]   full;
  logic [W/2-1:0] rounded;

  modport source
  (
    output full,
    input  rounded
  );

  modport rounder
  (
    input  full,
    output rounded
  );
endinterface

`default_nettype wire

// file: src/convergent_rounder.sv
`timescale 1ns/10ps
`default_nettype none

module convergent_rounder #(parameter int W = 32)
(
  round_if.rounder rif
);

  localparam int H = W / 2;
  localparam logic [H-1:0] HALF = {1'b1, {(H-1){1'b0}}};

  logic [H-1:0] upper;
  logic [H-1:0] lower;
  logic         bump;

  assign upper = rif.full[W-1:H];
  assign lower = rif.full[H-1:0];

  // Nearest, ties go to the even neighbour
  always_comb
  begin
    if (lower < HALF)
      bump = 1'b0;
    else if (lower > HALF)
      bump = 1'b1;
    else
      bump = upper[0];
  end

  assign rif.rounded = upper + {{(H-1){1'b0}}, bump};

endmodule

`default_nettype wire

// file: test/host_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_core_model
(
  input  wire logic              ref_clk,
  output logic                   op_valid,
  output mac_status_pkg::op_t    op_code,
  output logic                   op_long,
  output mac_status_pkg::scale_t scale_sel,
  output logic [31:0]            operand_y,
  output logic [31:0]            operand_x,
  output logic [31:0]            load_data
);
  initial
  begin
    op_valid = 1'b0;
    op_code = mac_status_pkg::OP_NONE;
    op_long = 1'b0;
    scale_sel = mac_status_pkg::SCALE_NONE;
    operand_y = 32'h0000_0000;
    operand_x = 32'h0000_0000;
    load_data = 32'h0000_0000;
  end

  // One request per falling edge
  task automatic issue(input mac_status_pkg::op_t c, input logic l,
                       input mac_status_pkg::scale_t s,
                       input logic [31:0] y, x, d);
    @(negedge ref_clk);
    op_valid = 1'b1;
    op_code = c;
    op_long = l;
    scale_sel = s;
    operand_y = y;
    operand_x = x;
    load_data = d;
  endtask

  // Released operands show garbage
  task automatic idle();
    @(negedge ref_clk);
    op_valid = 1'b0;
    operand_y = ~operand_y;
    operand_x = ~operand_x;
    load_data = ~load_data;
  endtask

  // Rounding off, accumulator, then saved status last
  task automatic restore(input logic [31:0] acc, sr);
    issue(mac_status_pkg::OP_LOAD_SR, 1'b1, scale_sel, 0, 0, 0);
    issue(mac_status_pkg::OP_LOAD_ACC, 1'b1, scale_sel, 0, 0, acc);
    issue(mac_status_pkg::OP_LOAD_SR, 1'b1, scale_sel, 0, 0, sr);
    idle();
  endtask
endmodule

`default_nettype wire

// file: test/multiply_accumulate_status_rounding_bench.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end

module multiply_accumulate_status_rounding_bench;
  localparam mac_status_pkg::op_t LA = mac_status_pkg::OP_LOAD_ACC;
  localparam mac_status_pkg::op_t LS = mac_status_pkg::OP_LOAD_SR;
  localparam mac_status_pkg::op_t SA = mac_status_pkg::OP_STORE_ACC;
  localparam mac_status_pkg::op_t SS = mac_status_pkg::OP_STORE_SR;
  localparam mac_status_pkg::op_t MC = mac_status_pkg::OP_MAC;
  localparam mac_status_pkg::op_t MS = mac_status_pkg::OP_MSAC;
  localparam mac_status_pkg::op_t MU = mac_status_pkg::OP_MULU;
  localparam mac_status_pkg::op_t ML = mac_status_pkg::OP_MULS;
  localparam mac_status_pkg::scale_t SN = mac_status_pkg::SCALE_NONE;
  localparam mac_status_pkg::scale_t SL = mac_status_pkg::SCALE_LEFT;
  localparam mac_status_pkg::scale_t SRT = mac_status_pkg::SCALE_RIGHT;

  logic                   ref_clk;
  logic                   srst;
  logic                   op_valid;
  mac_status_pkg::op_t    op_code;
  logic                   op_long;
  mac_status_pkg::scale_t scale_sel;
  logic [31:0]            operand_y;
  logic [31:0]            operand_x;
  logic [31:0]            load_data;
  logic [31:0]            result_data;
  logic                   result_valid;
  logic [31:0]            accum_value;
  logic [31:0]            status_value;
  int                     n_mismatch = 0;
  int                     checked = 0;

  host_core_model u_host (.ref_clk(ref_clk), .op_valid(op_valid),
    .op_code(op_code), .op_long(op_long), .scale_sel(scale_sel),
    .operand_y(operand_y), .operand_x(operand_x), .load_data(load_data));

  mac_status_unit DUT (.ref_clk(ref_clk), .srst(srst), .op_valid(op_valid),
    .op_code(op_code), .op_long(op_long), .scale_sel(scale_sel),
    .operand_y(operand_y), .operand_x(operand_x), .load_data(load_data),
    .result_data(result_data), .result_valid(result_valid),
    .accum_value(accum_value), .status_value(status_value));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] rnd16(input logic [31:0] v);
    logic [15:0] u;
    u = v[31:16];
    if (v[15:0] > 16'h8000 || (v[15:0] == 16'h8000 && v[16]))
      u = u + 16'h0001;
    return u;
  endfunction

  function automatic logic [31:0] frac(input logic [31:0] y, x,
                                       input logic rt, sub);
    logic signed [63:0] p;
    logic [31:0]        t;
    p = $signed(y) * $signed(x);
    p = p <<< 1;
    t = p[63:32];
    if (rt && (p[31:0] > 32'h8000_0000 || (p[31:0] == 32'h8000_0000 && p[32])))
      t = t + 32'h1;
    return sub ? 32'h0 - t : t;
  endfunction

  task automatic op(mac_status_pkg::op_t c, logic l, mac_status_pkg::scale_t s,
                    logic [31:0] y, x, d);
    u_host.issue(c, l, s, y, x, d);
    u_host.idle();
    `CHK(result_valid, c == SA || c == SS || c == MU || c == ML)
  endtask

  task automatic t_flags();
    op(LS, 1, SN, 0, 0, 32'h20);
    op(LA, 1, SN, 0, 0, 32'h8000_0000);
    `CHK(status_value[3:0], 4'h8)
    op(LA, 1, SN, 0, 0, 0);
    `CHK(status_value[3:0], 4'h4)
    op(mac_status_pkg::OP_MULS, 0, SN, 32'hfffe, 3, 0);
    `CHK(result_data, 32'hffff_fffa)
    op(MU, 0, SN, 32'hfffe, 3, 0);
    `CHK(result_data, 32'h0002_fffa)
    `CHK(status_value[3:0], 4'h4)
  endtask

  task automatic t_sticky();
    op(MC, 1, SN, 32'h8000_0000, 32'h8000_0000, 0);
    `CHK(status_value[1], 1'b1)
    op(MC, 1, SN, 0, 0, 0);
    `CHK(status_value[1], 1'b1)
    op(LA, 1, SN, 0, 0, 5);
    `CHK(status_value[1], 1'b0)
    op(MU, 1, SN, 32'hffff_ffff, 32'hffff_ffff, 0);
    `CHK(status_value[3:0], 4'h0)
    op(LS, 1, SN, 0, 0, 32'h03);
    `CHK(status_value, 32'h02)
    op(LS, 1, SN, 0, 0, 0);
    `CHK(status_value, 32'h00)
  endtask

  task automatic t_store();
    logic [31:0] v[4] = '{32'h1234_7fff, 32'h1234_8001, 32'h1234_8000,
                          32'h1235_8000};
    op(LS, 1, SN, 0, 0, 32'h60);
    foreach (v[i])
    begin
      u_host.issue(LA, 1, SN, 0, 0, v[i]);
      op(SA, 1, SN, 0, 0, 0);
      `CHK(result_data, {16'h0000, rnd16(v[i])})
      `CHK(accum_value, v[i])
    end
    op(LS, 1, SN, 0, 0, 32'h20);
    op(SA, 1, SN, 0, 0, 0);
    `CHK(result_data, 32'h1235_8000)
    op(LS, 1, SN, 0, 0, 32'h50);
    op(SA, 1, SN, 0, 0, 0);
    `CHK(result_data, 32'h1235_8000)
    op(SS, 1, SN, 0, 0, 0);
    `CHK(result_data, 32'h50)
  endtask

  task automatic t_frac();
    logic [31:0] sr[6] = '{32'h20, 32'h30, 32'h30, 32'h30, 32'h70, 32'h30};
    logic [31:0] y[6] = '{32'h1_8000, 32'h1_8000, 32'hc000, 32'h4000,
                          32'hffff_0000, 32'h1_8000};
    logic [31:0] x[6] = '{32'h8000, 32'h8000, 32'h8000, 32'h8000,
                          32'h4000_0000, 32'h8000};
    logic [31:0] e;
    foreach (sr[i])
    begin
      op(LS, 1, SN, 0, 0, sr[i]);
      op(LA, 1, SN, 0, 0, 0);
      op(i == 5 ? MS : MC, 1, i == 0 ? SL : SN, y[i], x[i], 0);
      e = frac(y[i], x[i], sr[i][4], i == 5);
      `CHK(accum_value, e)
      `CHK(status_value[3:2], {e[31], e == 0})
    end
  endtask

  task automatic t_int();
    logic [31:0] e[6] = '{32'hffff_fffe, 32'h0001_fffe, 32'hffff_fffc,
                          32'h0003_fffc, 32'hffff_ffff, 32'h0000_ffff};
    for (int i = 0; i < 6; i++)
    begin
      op(LS, 1, SN, 0, 0, (i % 2) ? 32'h50 : 32'h10);
      op(LA, 1, SN, 0, 0, 0);
      op(MC, 0, (i < 2) ? SN : ((i < 4) ? SL : SRT), 32'hffff, 2, 0);
      `CHK(accum_value, e[i])
    end
  endtask

  task automatic t_restore();
    u_host.restore(32'h1234_5678, 32'h72);
    `CHK(accum_value, 32'h1234_5678)
    `CHK(status_value, 32'h72)
    u_host.issue(LS, 1, SN, 0, 0, 0);
    op(SA, 1, SN, 0, 0, 0);
    `CHK(result_data, 32'h1234_5678)
  endtask

  task automatic report_and_stop();
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    srst = 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK(status_value, 32'h0)
    `CHK(accum_value, 32'h0)
    srst = 1'b0;
    t_flags();
    t_sticky();
    t_store();
    t_frac();
    t_int();
    t_restore();
    report_and_stop();
  end

  initial
  begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule

`default_nettype wire
